// >>> sba_map.vh
// constants for the system bus arbiter: owner codes, timing counts, pin widths
// assumes a single 100 MHz core clock
`ifndef SBA_MAP_VH
`define SBA_MAP_VH
`define SBA_OWN_CPU     2'h0
`define SBA_OWN_DMA     2'h1
`define SBA_OWN_REF     2'h2
`define SBA_OWN_EXT     2'h3
`define SBA_CLK_NS      10
`define SBA_REL_STATES  3
`define SBA_REL_WAIT    2'h2
`define SBA_HIGH_SAMPLES 2'h2
`define SBA_CS_W        8
`define SBA_ADDR_W      24
`define SBA_DATA_W      16
`define SBA_TOP_ADDR_W  4
`define SBA_CFG_W       8
`endif

// >>> sba_arbiter.v
// system bus arbiter: grants the external bus to cpu, dma engine, refresh or external master
// assumes masters signal safe release points as level inputs on core_clk
//
// Behaviour
// - simultaneous requests: only highest priority acknowledged
// - owner keeps bus until acknowledge withdrawn
// - cpu lowest; other requests preempt cpu
// - cpu bus access yields only at cycle boundary, not mid-word
// - cpu internal work: grant at once
// - cpu sleeping: grant immediately
// - dma preempted by refresh or external master
// - dma yields only after whole transfer
// - refresh requests bus, releases when done
// - external release only when release_enable set
// - released: float bus pins, acknowledge low
// - external master keeps bus while request low
// - request pin sampled each rising clock edge
// - two high samples end release, acknowledge high
// - at least three states before release
// - config writes apply from next bus cycle
// - cs direction writes apply at T3
// - top address writes apply at T3
`timescale 1ns/1ps
`include "sba_map.vh"

module sba_arbiter (
   // clock and reset
   input  wire                        core_clk,
   input  wire                        rst_n,
   // internal masters
   input  wire                        cpu_cycle_boundary,
   input  wire                        cpu_word_first_half,
   input  wire                        cpu_internal_op,
   input  wire                        cpu_sleep,
   input  wire                        dma_bus_req,
   input  wire                        dma_xfer_done,
   input  wire                        ref_bus_req,
   input  wire                        ref_cycle_done,
   output reg                         cpu_ack,
   output reg                         dma_ack,
   output reg                         ref_ack,
   // external master pins
   input  wire                        ext_bus_request_n,
   output reg                         ext_bus_ack_n,
   // control bit and register writes
   input  wire                        release_enable,
   input  wire                        cfg_write,
   input  wire                        cycle_start,
   input  wire                        t3_state,
   input  wire [`SBA_CFG_W-1:0]       bus_width_ctrl_reg,
   input  wire [`SBA_CFG_W-1:0]       access_state_ctrl_reg,
   input  wire [`SBA_CFG_W-1:0]       wait_ctrl_reg_high,
   input  wire [`SBA_CFG_W-1:0]       wait_ctrl_reg_low,
   input  wire                        pin_write,
   input  wire [`SBA_CS_W-1:0]        chip_select_ctrl_reg,
   input  wire [`SBA_TOP_ADDR_W-1:0]  release_ctrl_reg,
   output reg  [`SBA_CFG_W-1:0]       eff_bus_width,
   output reg  [`SBA_CFG_W-1:0]       eff_access_state,
   output reg  [`SBA_CFG_W-1:0]       eff_wait_high,
   output reg  [`SBA_CFG_W-1:0]       eff_wait_low,
   output reg  [`SBA_CS_W-1:0]        eff_cs_output,
   output reg  [`SBA_TOP_ADDR_W-1:0]  eff_top_addr_output,
   // pin output enables, low while driving
   output reg                         addr_oe_n,
   output reg                         data_oe_n,
   output reg                         addr_strobe_oe_n,
   output reg                         read_strobe_oe_n,
   output reg                         upper_write_strobe_oe_n,
   output reg                         lower_write_strobe_oe_n,
   output reg  [`SBA_CS_W-1:0]        chip_select_oe_n
);

   localparam [1:0] ST_CPU   = `SBA_OWN_CPU;
   localparam [1:0] ST_DMA   = `SBA_OWN_DMA;
   localparam [1:0] ST_REF   = `SBA_OWN_REF;
   localparam [1:0] ST_EXT   = `SBA_OWN_EXT;
   // low samples counted before release; the count plus sync gives three states
   localparam [1:0] REL_WAIT = `SBA_REL_WAIT;

   reg        rst_s1;
   reg        rst_s2;
   reg        req_s1;
   reg        req_s2;
   reg [1:0]  owner;
   reg [1:0]  next_owner;
   reg [1:0]  low_cnt;
   reg [1:0]  high_cnt;
   reg        pend_cfg;
   reg [`SBA_CFG_W-1:0] hold_bw;
   reg [`SBA_CFG_W-1:0] hold_as;
   reg [`SBA_CFG_W-1:0] hold_wh;
   reg [`SBA_CFG_W-1:0] hold_wl;
   reg        next_release;

   wire ext_want;
   wire ext_ready;
   wire ext_done;
   wire cpu_can_yield;

   // owner code decode shared by grants and pin enables
   function is_owner;
      input [1:0] code;
      input [1:0] who;
      begin
         is_owner = (code == who);
      end
   endfunction

   // reset release synchronizer
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // request pin sampled through two flops on each rising edge
   always @(posedge core_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         req_s1 <= 1'b1;
         req_s2 <= 1'b1;
      end else begin
         req_s1 <= ext_bus_request_n;
         req_s2 <= req_s1;
      end
   end

   assign ext_want  = !req_s2 && release_enable;
   // low count builds the minimum lead time before release
   assign ext_ready = ext_want && (low_cnt == REL_WAIT);
   assign ext_done  = (high_cnt == `SBA_HIGH_SAMPLES);
   // mid-word byte pair never split; internal op or sleep yields at once
   assign cpu_can_yield = cpu_internal_op || cpu_sleep ||
                          (cpu_cycle_boundary && !cpu_word_first_half);

   // low count: an early rise of the request starts the lead time again
   always @(posedge core_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         low_cnt <= 2'h0;
      end else begin
         if (req_s2 || is_owner(owner, ST_EXT))
            low_cnt <= 2'h0;
         else if (low_cnt != REL_WAIT)
            low_cnt <= low_cnt + 2'h1;
      end
   end

   // high count: only counts while the external master owns the bus
   always @(posedge core_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         high_cnt <= 2'h0;
      end else begin
         if (!is_owner(owner, ST_EXT) || !req_s2)
            high_cnt <= 2'h0;
         else if (!ext_done)
            high_cnt <= high_cnt + 2'h1;
      end
   end

   // priority: external > refresh > dma > cpu
   always @* begin
      next_owner = owner;
      case (owner)
         ST_CPU: begin
            if (cpu_can_yield) begin
               if (ext_ready)
                  next_owner = ST_EXT;
               else if (ref_bus_req)
                  next_owner = ST_REF;
               else if (dma_bus_req)
                  next_owner = ST_DMA;
            end
         end
         ST_DMA: begin
            if (dma_xfer_done) begin
               if (ext_ready)
                  next_owner = ST_EXT;
               else if (ref_bus_req)
                  next_owner = ST_REF;
               else if (!dma_bus_req)
                  next_owner = ST_CPU;
            end
         end
         ST_REF: begin
            if (ref_cycle_done) begin
               if (ext_ready)
                  next_owner = ST_EXT;
               else if (dma_bus_req)
                  next_owner = ST_DMA;
               else
                  next_owner = ST_CPU;
            end
         end
         ST_EXT: begin
            if (ext_done) begin
               if (ref_bus_req)
                  next_owner = ST_REF;
               else if (dma_bus_req)
                  next_owner = ST_DMA;
               else
                  next_owner = ST_CPU;
            end
         end
         default: next_owner = ST_CPU;
      endcase
   end

   // one decode feeds the acknowledge pin and every output enable
   always @* begin
      next_release = is_owner(next_owner, ST_EXT);
   end

   // ownership and acknowledges, changed only at release points
   always @(posedge core_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         owner         <= ST_CPU;
         cpu_ack       <= 1'b1;
         dma_ack       <= 1'b0;
         ref_ack       <= 1'b0;
         ext_bus_ack_n <= 1'b1;
         addr_oe_n     <= 1'b0;
         data_oe_n     <= 1'b0;
         addr_strobe_oe_n        <= 1'b0;
         read_strobe_oe_n        <= 1'b0;
         upper_write_strobe_oe_n <= 1'b0;
         lower_write_strobe_oe_n <= 1'b0;
         chip_select_oe_n        <= {`SBA_CS_W{1'b0}};
      end else begin
         owner   <= next_owner;
         cpu_ack <= is_owner(next_owner, ST_CPU);
         dma_ack <= is_owner(next_owner, ST_DMA);
         ref_ack <= is_owner(next_owner, ST_REF);
         ext_bus_ack_n <= !next_release;
         addr_oe_n     <= next_release;
         data_oe_n     <= next_release;
         addr_strobe_oe_n        <= next_release;
         read_strobe_oe_n        <= next_release;
         upper_write_strobe_oe_n <= next_release;
         lower_write_strobe_oe_n <= next_release;
         chip_select_oe_n        <= {`SBA_CS_W{next_release}};
      end
   end

   // configuration writes held until the next bus cycle starts
   always @(posedge core_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         pend_cfg            <= 1'b0;
         hold_bw             <= {`SBA_CFG_W{1'b0}};
         hold_as             <= {`SBA_CFG_W{1'b0}};
         hold_wh             <= {`SBA_CFG_W{1'b0}};
         hold_wl             <= {`SBA_CFG_W{1'b0}};
         eff_bus_width       <= {`SBA_CFG_W{1'b0}};
         eff_access_state    <= {`SBA_CFG_W{1'b0}};
         eff_wait_high       <= {`SBA_CFG_W{1'b0}};
         eff_wait_low        <= {`SBA_CFG_W{1'b0}};
      end else begin
         if (cfg_write) begin
            pend_cfg <= 1'b1;
            hold_bw  <= bus_width_ctrl_reg;
            hold_as  <= access_state_ctrl_reg;
            hold_wh  <= wait_ctrl_reg_high;
            hold_wl  <= wait_ctrl_reg_low;
         end else if (pend_cfg && cycle_start) begin
            pend_cfg         <= 1'b0;
            eff_bus_width    <= hold_bw;
            eff_access_state <= hold_as;
            eff_wait_high    <= hold_wh;
            eff_wait_low     <= hold_wl;
         end
      end
   end

   // pin function selects switch inside the write cycle, at its T3 state
   always @(posedge core_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         eff_cs_output       <= {`SBA_CS_W{1'b0}};
         eff_top_addr_output <= {`SBA_TOP_ADDR_W{1'b0}};
      end else begin
         if (pin_write && t3_state) begin
            eff_cs_output       <= chip_select_ctrl_reg;
            eff_top_addr_output <= release_ctrl_reg;
         end
      end
   end

endmodule

// >>> sba_properties.sv
// checker for the system bus arbiter, sees only top-level ports
// assumes a single core_clk domain with async active-low rst_n
`timescale 1ns/1ps
module sba_properties (
   // clock and reset
   input wire       core_clk,
   input wire       rst_n,
   // masters and grants
   input wire       cpu_cycle_boundary, cpu_word_first_half, cpu_internal_op, cpu_sleep,
   input wire       dma_bus_req, dma_xfer_done, cpu_ack, dma_ack, ref_ack,
   // external pins and writes
   input wire       ext_bus_request_n, ext_bus_ack_n, release_enable,
   input wire       cycle_start, t3_state, pin_write, addr_oe_n, data_oe_n,
   input wire       addr_strobe_oe_n, read_strobe_oe_n,
   input wire       upper_write_strobe_oe_n, lower_write_strobe_oe_n,
   input wire [7:0] eff_bus_width, eff_cs_output, chip_select_oe_n,
   input wire [3:0] eff_top_addr_output
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_req_high;
      ext_bus_request_n [*7];
   endsequence
   a_single_grant: assert property ($onehot({cpu_ack, dma_ack, ref_ack, !ext_bus_ack_n}))
      else $error("more or fewer than one grant");
   a_cpu_yield_point: assert property ($fell(cpu_ack) |->
      $past(cpu_internal_op || cpu_sleep || cpu_cycle_boundary && !cpu_word_first_half))
      else $error("cpu lost bus mid cycle");
   a_dma_whole_xfer: assert property ($fell(dma_ack) |-> $past(dma_xfer_done || !dma_bus_req))
      else $error("dma lost bus mid transfer");
   a_ext_enabled: assert property ($fell(ext_bus_ack_n) |-> $past(release_enable))
      else $error("bus released while disabled");
   a_bus_floated: assert property (!ext_bus_ack_n |-> addr_oe_n && data_oe_n && &chip_select_oe_n)
      else $error("pins driven while released");
   a_strobes_floated: assert property (!ext_bus_ack_n |-> addr_strobe_oe_n &&
      read_strobe_oe_n && upper_write_strobe_oe_n && lower_write_strobe_oe_n)
      else $error("strobes driven while released");
   a_pins_driven: assert property (ext_bus_ack_n |-> !addr_oe_n && !data_oe_n)
      else $error("pins floated while owned");
   a_ext_lead: assert property ($fell(ext_bus_ack_n) |->
      !$past(ext_bus_request_n, 3) && !$past(ext_bus_request_n, 2)) else $error("release too early");
   a_ext_hold: assert property (!ext_bus_ack_n && !ext_bus_request_n |=> !ext_bus_ack_n)
      else $error("external master lost bus");
   a_ext_end: assert property (s_req_high |-> ext_bus_ack_n)
      else $error("release not ended");
   a_end_samples: assert property ($rose(ext_bus_ack_n) |->
      $past(ext_bus_request_n, 2) && $past(ext_bus_request_n, 3)) else $error("release ended early");
   a_cfg_at_cycle: assert property ($changed(eff_bus_width) |->
      $past(cycle_start) || $past(cycle_start, 2)) else $error("config applied mid cycle");
   a_pin_at_t3: assert property ($changed({eff_cs_output, eff_top_addr_output}) |->
      $past(pin_write && t3_state)) else $error("pin function changed outside T3");
endmodule
bind sba_arbiter sba_properties u_props (.core_clk, .rst_n, .cpu_cycle_boundary,
   .cpu_word_first_half, .cpu_internal_op, .cpu_sleep, .dma_bus_req, .dma_xfer_done, .cpu_ack,
   .dma_ack, .ref_ack, .ext_bus_request_n, .ext_bus_ack_n, .release_enable, .cycle_start,
   .t3_state, .pin_write, .addr_oe_n, .data_oe_n, .addr_strobe_oe_n, .read_strobe_oe_n,
   .upper_write_strobe_oe_n, .lower_write_strobe_oe_n, .eff_bus_width, .eff_cs_output,
   .chip_select_oe_n, .eff_top_addr_output);

// >>> sba_ext_master.sv
// external bus master model: asks with an active-low request, keeps it for hold cycles
// assumes request and acknowledge pins on core_clk; drives at the falling edge
`timescale 1ns/1ps
module sba_ext_master (
   input wire       core_clk, go, ext_bus_ack_n,
   input wire [3:0] hold,
   output reg       ext_bus_request_n
);
   reg [3:0] cnt;
   initial begin
      ext_bus_request_n = 1'b1;
      cnt = 4'h3;
   end
   always @(negedge core_clk) begin
      if (!ext_bus_request_n) begin
         // keep asking until acknowledged, then own the bus for hold cycles
         if (!ext_bus_ack_n) begin
            if (cnt >= hold) begin
               ext_bus_request_n <= 1'b1;
               cnt <= 4'h0;
            end else cnt <= cnt + 4'h1;
         end
      end else if (go && cnt >= 4'h3 && ext_bus_ack_n) begin
         ext_bus_request_n <= 1'b0;
         cnt <= 4'h0;
      end else if (cnt < 4'h3) cnt <= cnt + 4'h1;
   end
endmodule

// >>> sba_tb.sv
// self-checking bench for the system bus arbiter
// assumes the external master model and the bound checker
`timescale 1ns/1ps
module testbench;
   reg core_clk=0, rst_n=0, cpu_cycle_boundary=1, cpu_word_first_half=0, cpu_internal_op=0;
   reg cpu_sleep=0, dma_bus_req=0, dma_xfer_done=1, ref_bus_req=0, ref_cycle_done=0;
   reg release_enable=1, cfg_write=0, cycle_start=0, t3_state=0, pin_write=0, go=0;
   reg [7:0] bus_width_ctrl_reg=0, access_state_ctrl_reg=0, wait_ctrl_reg_high=0;
   reg [7:0] wait_ctrl_reg_low=0, chip_select_ctrl_reg=0;
   reg [3:0] release_ctrl_reg=0, hold=0, last=4'b1000;
   reg [3:0] q[$];
   wire cpu_ack, dma_ack, ref_ack, ext_bus_ack_n, ext_bus_request_n, addr_oe_n, data_oe_n;
   wire addr_strobe_oe_n, read_strobe_oe_n, upper_write_strobe_oe_n, lower_write_strobe_oe_n;
   wire [7:0] eff_bus_width, eff_access_state, eff_wait_high, eff_wait_low;
   wire [7:0] eff_cs_output, chip_select_oe_n;
   wire [3:0] eff_top_addr_output;
   wire [3:0] own = {cpu_ack, dma_ack, ref_ack, ~ext_bus_ack_n};
   integer err_count=0, checks=0, cyc=0, i;
   sba_arbiter DUT (.core_clk, .rst_n, .cpu_cycle_boundary, .cpu_word_first_half,
      .cpu_internal_op, .cpu_sleep, .dma_bus_req, .dma_xfer_done, .ref_bus_req, .ref_cycle_done,
      .cpu_ack, .dma_ack, .ref_ack, .ext_bus_request_n, .ext_bus_ack_n, .release_enable,
      .cfg_write, .cycle_start, .t3_state, .bus_width_ctrl_reg, .access_state_ctrl_reg,
      .wait_ctrl_reg_high, .wait_ctrl_reg_low, .pin_write, .chip_select_ctrl_reg,
      .release_ctrl_reg, .eff_bus_width, .eff_access_state, .eff_wait_high, .eff_wait_low,
      .eff_cs_output, .eff_top_addr_output, .addr_oe_n, .data_oe_n, .addr_strobe_oe_n,
      .read_strobe_oe_n, .upper_write_strobe_oe_n, .lower_write_strobe_oe_n, .chip_select_oe_n);
   sba_ext_master u_ext (.core_clk, .go, .ext_bus_ack_n, .hold, .ext_bus_request_n);
   always #5 core_clk = ~core_clk;
   task chk(input string nm, input [31:0] e, input [31:0] g);
      checks++;
      if (e !== g) begin
         err_count++;
         $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task cy(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   task wq;
      for (i = 0; i < 60 && q.size() > 0; i++) @(negedge core_clk);
      chk("pending grants", 0, q.size());
   endtask
   // every change of owner takes the oldest expected owner off the queue, and fails when the queue is empty
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         stop_test;
      end
      #1;
      if (rst_n && own !== last) begin
         chk("owner", (q.size() > 0) ? q.pop_front() : last, own);
         last = own;
      end
   end
   initial begin
      hold = $urandom(62) % 8;
      cy(20); rst_n = 1; cy(4);
      chk("default owner", 4'b1000, own);
      dma_bus_req = 1; ref_bus_req = 1; q.push_back(4'b0010); wq;
      ref_bus_req = 0; ref_cycle_done = 1; q.push_back(4'b0100); cy(1); ref_cycle_done = 0; wq;
      dma_xfer_done = 0; go = 1; cy(2); go = 0; cy(12);
      q.push_back(4'b0001); dma_xfer_done = 1; wq; dma_bus_req = 0;
      chk("floated", 14'h3FFF, {addr_oe_n, data_oe_n, addr_strobe_oe_n, read_strobe_oe_n,
         upper_write_strobe_oe_n, lower_write_strobe_oe_n, chip_select_oe_n});
      q.push_back(4'b1000); wq;
      cpu_cycle_boundary = 0; cpu_word_first_half = 1; dma_bus_req = 1; cy(10);
      q.push_back(4'b0100); cpu_cycle_boundary = 1; cpu_word_first_half = 0; wq;
      dma_bus_req = 0; q.push_back(4'b1000); wq; cpu_cycle_boundary = 0;
      for (integer k = 0; k < 2; k++) begin
         {cpu_sleep, cpu_internal_op} = k + 1; ref_bus_req = 1;
         q.push_back(4'b0010); wq;
         ref_bus_req = 0; ref_cycle_done = 1; q.push_back(4'b1000); cy(1); ref_cycle_done = 0; wq;
      end
      {cpu_sleep, cpu_internal_op, cpu_cycle_boundary} = 3'b001;
      release_enable = 0; hold = $urandom % 8; go = 1; cy(2); go = 0; cy(20);
      q.push_back(4'b0001); release_enable = 1; wq; q.push_back(4'b1000); wq;
      {bus_width_ctrl_reg, access_state_ctrl_reg, wait_ctrl_reg_high, wait_ctrl_reg_low} = $urandom;
      cfg_write = 1; cy(1); cfg_write = 0; cy(3);
      chk("config before cycle", 0,
         {eff_bus_width, eff_access_state, eff_wait_high, eff_wait_low});
      cycle_start = 1; cy(1); cycle_start = 0; cy(2);
      chk("config", {bus_width_ctrl_reg, access_state_ctrl_reg, wait_ctrl_reg_high, wait_ctrl_reg_low},
         {eff_bus_width, eff_access_state, eff_wait_high, eff_wait_low});
      {chip_select_ctrl_reg, release_ctrl_reg} = $urandom; pin_write = 1; cy(2);
      chk("pins before T3", 0, {eff_cs_output, eff_top_addr_output});
      t3_state = 1; cy(1); pin_write = 0; t3_state = 0; cy(1);
      chk("pins", {chip_select_ctrl_reg, release_ctrl_reg}, {eff_cs_output, eff_top_addr_output});
      stop_test;
   end
endmodule
